// ==== common/sar_seq_pkg.sv ====
// package of constants and types for the conversion sequencer
// What this block does
// R1: convert strobe rising edge starts conversion
// R2: open ground switches, then ground arrays
// R3: two identical fourteen element arrays
// R4: binary search, msb first, comparator decides
// R5: back to acquisition, result and busy
// R6: internal clock paces bits, no serial clock
// R7: straight binary unsigned result code
// R8: over range saturates at all ones
// R9: under range saturates at all zeros
// R10: power down after every conversion
// R11: conversion ignores later strobe changes
// R12: result belongs to same conversion
// R13: latch serial mode input at strobe edge
// R14: hold old result, update with completion
`default_nettype none
package sar_seq_pkg;
  localparam int RES_BITS = 14;                    // result width
  localparam logic [13:0] CODE_ZERO = 14'h0000;    // reset result
  localparam logic [13:0] CODE_FULL = 14'h3fff;    // all ones code
  localparam logic [13:0] CODE_MID  = 14'h2000;    // first trial code
  localparam int SETTLE_NS   = 200;                // comparator settle time per bit
  localparam int CLK_NS      = 100;                // sys_clk period
  localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYC - 1);

  // switch drive toward the analog array
  typedef struct packed {
    logic        pos_array_ground_switch;  // high = closed
    logic        neg_array_ground_switch;  // high = closed
    logic        arrays_on_inputs;         // high = sampling inputs
    logic [13:0] bit_to_ref;               // per element: 1 = ref, 0 = gnd
  } switch_drive_t;

  // switch drive words for the fixed steps of the sequence
  localparam switch_drive_t DRIVE_IDLE   = '{1'b1, 1'b1, 1'b1, 14'h0000}; // tracking inputs
  localparam switch_drive_t DRIVE_OPEN   = '{1'b0, 1'b0, 1'b1, 14'h0000}; // grounds open first
  localparam switch_drive_t DRIVE_GROUND = '{1'b0, 1'b0, 1'b0, 14'h0000}; // arrays on ground
endpackage : sar_seq_pkg
`default_nettype wire

// ==== core/sar_bit_step.sv ====
// one binary search step: keep or clear trial bit, set next trial bit
`timescale 1ns/1ps
`default_nettype none
module sar_bit_step (
  // trial state
  input  wire logic [13:0] trial,
  input  wire logic [3:0]  bit_idx,
  // comparator: high = trial too large
  input  wire logic        cmp_high,
  // next trial
  output logic      [13:0] nxt_trial
);
  // clear the tested bit when over, arm the next lower bit
  always_comb begin
    nxt_trial = trial;
    if (cmp_high) begin
      nxt_trial[bit_idx] = 1'b0; // R4
    end
    if (bit_idx != 4'h0) begin
      nxt_trial[bit_idx - 4'h1] = 1'b1; // R4
    end
  end
endmodule : sar_bit_step
`default_nettype wire

// ==== core/sar_conversion_sequencer.sv ====
// conversion sequencer top: strobe, switches, binary search, result
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // host pins
  input  wire logic                       convert_strobe,
  input  wire logic                       serial_mode_input,
  // comparator from analog core
  input  wire logic                       cmp_high,
  input  wire logic                       over_range,
  input  wire logic                       under_range,
  // switch drive
  output sar_seq_pkg::switch_drive_t      sw_ff,
  // results
  output logic [13:0]                     result_ff,
  output logic                            done_ff,
  output logic                            busy_ff,
  output logic                            chain_mode_ff,
  output logic                            power_down_ff
);
  // acquisition, the two switch steps, then trial and settle per bit
  typedef enum logic [2:0] {ACQ, OPEN_SW, GROUND, TRIAL, SETTLE} state_t;
  state_t      state_ff;            // sequencer state
  logic [1:0]  strobe_sync_ff;      // strobe synchroniser
  logic        strobe_prev_ff;      // strobe level one cycle back
  logic [1:0]  mode_sync_ff;        // mode input synchroniser
  logic [13:0] trial_ff;            // code under test
  logic [13:0] nxt_trial;           // step result
  logic [3:0]  bit_ff;              // bit under test
  logic [3:0]  wait_ff;             // settle counter
  logic        strobe_rise;         // strobe edge
  logic        conv_start;          // edge accepted in acquisition
  logic        sample_done;         // last bit decided

  // strobe pin passes two flops; only stage two is read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobe_sync_ff <= 2'h0;
    end else begin
      strobe_sync_ff <= {strobe_sync_ff[0], convert_strobe};
    end
  end

  // mode pin has its own pair, same depth, so both agree at the edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_sync_ff <= 2'h0;
    end else begin
      mode_sync_ff <= {mode_sync_ff[0], serial_mode_input};
    end
  end

  // edge detector; resets low to match the idle strobe level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobe_prev_ff <= 1'b0;
    end else begin
      strobe_prev_ff <= strobe_sync_ff[1];
    end
  end

  // rise seen on the synchronised strobe
  assign strobe_rise = strobe_sync_ff[1] & ~strobe_prev_ff;
  // a rise outside acquisition is dropped, never queued
  assign conv_start  = (state_ff == ACQ) && strobe_rise; // R11
  // final settle cycle of bit zero: the code is complete
  assign sample_done = (state_ff == SETTLE) && (wait_ff == 4'h0) && (bit_ff == 4'h0);

  // one search step; the comparator is read only on the last settle cycle
  sar_bit_step u_step (
    .trial     (trial_ff),
    .bit_idx   (bit_ff),
    .cmp_high  (cmp_high),
    .nxt_trial (nxt_trial)
  );

  // main sequence, paced by sys_clk only, never a serial clock
  always_ff @(posedge sys_clk) begin // R6
    if (rst) begin
      state_ff <= ACQ;
      trial_ff <= sar_seq_pkg::CODE_ZERO;
      bit_ff   <= 4'h0;
      wait_ff  <= 4'h0;
    end else begin
      unique case (state_ff)
        ACQ: begin
          // host owns acquisition time; edge starts conversion
          // a strobe that rises early just gives a short acquisition
          if (strobe_rise) begin
            state_ff <= OPEN_SW; // R1
          end
        end
        OPEN_SW: begin
          state_ff <= GROUND; // R2
        end
        GROUND: begin
          trial_ff <= sar_seq_pkg::CODE_MID; // R4
          bit_ff   <= 4'(sar_seq_pkg::RES_BITS - 1); // R3
          state_ff <= TRIAL;
        end
        TRIAL: begin
          wait_ff  <= sar_seq_pkg::SETTLE_LAST;
          state_ff <= SETTLE;
        end
        SETTLE: begin
          // strobe is not looked at here: conversion runs to end
          if (wait_ff != 4'h0) begin // R11
            wait_ff <= wait_ff - 4'h1;
          end else begin
            trial_ff <= nxt_trial; // R4
            if (bit_ff == 4'h0) begin
              state_ff <= ACQ; // R5
            end else begin
              bit_ff   <= bit_ff - 4'h1;
              state_ff <= TRIAL;
            end
          end
        end
      endcase
    end
  end

  // switch drive: ground switches open before arrays leave inputs;
  // each step is its own registered cycle so the order cannot race
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_ff <= sar_seq_pkg::DRIVE_IDLE;
    end else begin
      unique case (state_ff)
        ACQ: begin
          if (strobe_rise) begin
            // step one: grounds open, arrays still hold the sample
            sw_ff <= sar_seq_pkg::DRIVE_OPEN; // R2
          end else begin
            // tracking: grounds closed, arrays on the inputs
            sw_ff <= sar_seq_pkg::DRIVE_IDLE;
          end
        end
        OPEN_SW: begin
          // step two: arrays leave the inputs, all elements on ground
          sw_ff <= sar_seq_pkg::DRIVE_GROUND; // R2
        end
        GROUND: begin
          // keep every element grounded while the first trial loads;
          // the stale code of the last conversion must not show here
          sw_ff <= sar_seq_pkg::DRIVE_GROUND; // R2
        end
        TRIAL, SETTLE: begin
          if (sample_done) begin
            // back to tracking in the same step as done
            sw_ff <= sar_seq_pkg::DRIVE_IDLE; // R5
          end else begin
            // identical drive feeds both arrays
            sw_ff <= sar_seq_pkg::switch_drive_t'{1'b0, 1'b0, 1'b0, trial_ff}; // R3 R4
          end
        end
        default: begin
          // unused state codes: park the arrays on their inputs
          sw_ff <= sar_seq_pkg::DRIVE_IDLE;
        end
      endcase
    end
  end

  // result register: old code held, replaced in one step at end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_ff <= sar_seq_pkg::CODE_ZERO;
      done_ff   <= 1'b0;
    end else begin
      // done marks the single cycle in which the new code lands
      done_ff <= sample_done; // R5
      if (sample_done) begin
        // unsigned straight binary; range flags saturate
        if (over_range) begin
          result_ff <= sar_seq_pkg::CODE_FULL; // R8
        end else if (under_range) begin
          result_ff <= sar_seq_pkg::CODE_ZERO; // R9
        end else begin
          result_ff <= nxt_trial; // R7 R12 R14
        end
      end
    end
  end

  // busy covers the conversion, from accepted edge to last decision
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else if (conv_start) begin
      busy_ff <= 1'b1;
    end else if (sample_done) begin
      // falls in the same step as done and the new code
      busy_ff <= 1'b0; // R5
    end
  end

  // power down between conversions, with no host command needed;
  // the analog core is only awake while a conversion runs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_down_ff <= 1'b1;
    end else if (conv_start) begin
      // wake at the accepted edge so the first decision is ready
      power_down_ff <= 1'b0;
    end else if (sample_done) begin
      power_down_ff <= 1'b1; // R10
    end
  end

  // mode selection captured at the strobe edge; held for the readout
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chain_mode_ff <= 1'b0;
    end else if (conv_start) begin
      // a low mode input at the edge selects chain mode
      chain_mode_ff <= ~mode_sync_ff[1]; // R13
    end
  end
endmodule : sar_conversion_sequencer
`default_nettype wire

// ==== tb/sar_analog_model.sv ====
// comparator model of the analog core
`timescale 1ns/1ps
`default_nettype none
module sar_analog_model (
  // trial drive and held input
  input  wire sar_seq_pkg::switch_drive_t sw,
  input  wire logic [13:0]                vin,
  // high when trial exceeds input
  output logic                            cmp_high
);
  assign cmp_high = sw.bit_to_ref > vin;
endmodule : sar_analog_model
`default_nettype wire

// ==== tb/sar_conversion_sequencer_tb_top.sv ====
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_tb_top;
  logic sys_clk = 0, rst = 1, stb = 0, mode = 0, ovr = 0, und = 0, cmp_high;
  logic [13:0] vin = 14'h0000, result_ff;
  logic done_ff, busy_ff, chain_ff, pd_ff;
  sar_seq_pkg::switch_drive_t sw_ff;
  logic [14:0] exp_q[$];  // expected {chain, code}
  logic [15:0] lfsr = 16'h0006;
  logic [13:0] codes [6] = '{14'h0000, 14'h0001, 14'h1fff, 14'h2000, 14'h2001, 14'h3fff};
  int err_total = 0, cmp_count = 0;
  bit hung = 0;  // a conversion hung: skip the rest
  always #50 sys_clk = ~sys_clk;
  sar_conversion_sequencer DUT (.sys_clk(sys_clk), .rst(rst), .convert_strobe(stb),
    .serial_mode_input(mode), .cmp_high(cmp_high), .over_range(ovr), .under_range(und),
    .sw_ff(sw_ff), .result_ff(result_ff), .done_ff(done_ff), .busy_ff(busy_ff),
    .chain_mode_ff(chain_ff), .power_down_ff(pd_ff));
  sar_analog_model model (.sw(sw_ff), .vin(vin), .cmp_high(cmp_high));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // one conversion; g toggles the strobe early on, mode flips mid-run
  task automatic conv(input logic [13:0] v, input logic o, u, m, g);
    int n;
    logic [13:0] want;
    if (hung) return;
    @(posedge sys_clk) #10;
    vin = v;
    ovr = o;
    und = u;
    mode = m;
    stb = 1;
    want = o ? sar_seq_pkg::CODE_FULL : (u ? sar_seq_pkg::CODE_ZERO : v);
    exp_q.push_back({~m, want});
    for (n = 0; n < 100 && done_ff !== 1'b1; n++) begin
      @(posedge sys_clk) #10;
      if (g && n < 30) stb = n[0];
      if (n == 8) mode = ~m;
    end
    if (n == 100) begin
      err_total++;
      hung = 1;
      $display("MISMATCH %0t no done within bound", $time);
    end
    stb = 0;
    repeat (3) @(posedge sys_clk);
    $display("test done code %h", v);
  endtask : conv
  // each done pulse takes the oldest note
  always @(negedge sys_clk) begin
    if (done_ff === 1'b1) begin
      cmp_count++;
      if (exp_q.size() == 0 || {chain_ff, result_ff} !== exp_q[0]) begin
        err_total++;
        $display("MISMATCH %0t got %b %h", $time, chain_ff, result_ff);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #10 rst = 0;
    foreach (codes[i]) conv(codes[i], 0, 0, i[0], 0);
    conv(14'h1234, 1, 0, 0, 0);
    conv(14'h1234, 0, 1, 1, 0);
    conv(14'h0abc, 1, 1, 1, 0);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      conv(lfsr[13:0], 0, 0, lfsr[14], 1);
    end
    if (exp_q.size() != 0) begin
      err_total++;
      $display("MISMATCH %0t result never arrived", $time);
    end
    results();
  end
endmodule : sar_conversion_sequencer_tb_top
`default_nettype wire

// ==== tb/sar_seq_chk.sv ====
// port assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_seq_chk (
  // watched ports
  input wire logic                       sys_clk,
  input wire logic                       rst,
  input wire sar_seq_pkg::switch_drive_t sw_ff,
  input wire logic [13:0]                result_ff,
  input wire logic                       done_ff,
  input wire logic                       busy_ff,
  input wire logic                       power_down_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // sw_ff bits: 16 pos ground, 15 neg ground, 14 on inputs, 13:0 trial
  property p_open; $rose(busy_ff) |-> sw_ff[16:15] == 2'b00 && sw_ff[14]; endproperty
  a_open: assert property (p_open) else $error("grounds not opened first");
  property p_gnd; $rose(busy_ff) |=> !sw_ff[14] && sw_ff[13:0] == 14'h0000; endproperty
  a_gnd: assert property (p_gnd) else $error("arrays left on inputs");
  property p_order; !sw_ff[14] |-> sw_ff[16:15] == 2'b00; endproperty
  a_order: assert property (p_order) else $error("arrays off inputs, grounds closed");
  property p_track; sw_ff[14] |-> sw_ff[13:0] == 14'h0000; endproperty
  a_track: assert property (p_track) else $error("elements switched while sampling");
  property p_msb; $rose(busy_ff) |-> ##[1:3] sw_ff[13:0] == 14'h2000; endproperty
  a_msb: assert property (p_msb) else $error("first trial not msb");
  property p_len; $rose(busy_ff) |-> busy_ff[*8] ##[32:40] done_ff; endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_done; done_ff |-> !busy_ff && power_down_ff && sw_ff == 17'h1c000; endproperty
  a_done: assert property (p_done) else $error("not idle at done");
  property p_pulse; done_ff |=> !done_ff; endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_hold; !done_ff |-> $stable(result_ff); endproperty
  a_hold: assert property (p_hold) else $error("result moved without done");
  property p_pd; busy_ff |-> !power_down_ff; endproperty
  a_pd: assert property (p_pd) else $error("powered down while busy");
endmodule : sar_seq_chk
bind sar_conversion_sequencer sar_seq_chk chk (.sys_clk(sys_clk), .rst(rst), .sw_ff(sw_ff),
  .result_ff(result_ff), .done_ff(done_ff), .busy_ff(busy_ff), .power_down_ff(power_down_ff));
`default_nettype wire
